/* File: gos_global_overflow_status_clear.sv */
/*
 * gos_global_overflow_status_clear: per-thread global overflow status bank
 * with its write-one-to-clear companion and an interrupt mask, as a classic
 * Wishbone slave. Assumes event inputs are one-cycle pulses from logic on
 * clk_in, and a master that holds each request until it sees ack.
 */
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps

module gos_global_overflow_status_clear
	import gos_pkg::*;
#(
	parameter int ADR_W = 12
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic gp_counter0_overflow_in,
	input wire logic gp_counter1_overflow_in,
	input wire logic gp_counter2_overflow_in,
	input wire logic gp_counter3_overflow_in,
	input wire logic fixed_counter0_overflow_in,
	input wire logic fixed_counter1_overflow_in,
	input wire logic fixed_counter2_overflow_in,
	input wire logic trace_table_interrupt_in,
	input wire logic uncore_overflow_in,
	input wire logic debug_store_save_overflow_in,
	input wire logic condition_changed_in,
	output logic [63:0] global_overflow_status_out,
	output logic irq_out
);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------

	// byte address to register word
	function automatic gos_reg_sel_e decode_word(input logic [ADR_W-1:0] adr);
		gos_reg_sel_e sel;
		sel = GOS_SEL_NONE;
		unique case (adr[11:0])
			ADR_STATUS_LO: sel = GOS_SEL_STATUS_LO;
			ADR_STATUS_HI: sel = GOS_SEL_STATUS_HI;
			ADR_CLEAR_LO: sel = GOS_SEL_CLEAR_LO;
			ADR_CLEAR_HI: sel = GOS_SEL_CLEAR_HI;
			ADR_MASK_LO: sel = GOS_SEL_MASK_LO;
			ADR_MASK_HI: sel = GOS_SEL_MASK_HI;
			default: sel = GOS_SEL_NONE;
		endcase
		if (ADR_W > 12 && (adr >> 12) != '0) begin
			sel = GOS_SEL_NONE;
		end
		return sel;
	endfunction : decode_word

	// byte enables to a bit mask
	function automatic logic [31:0] lane_bits(input logic [3:0] sel);
		logic [31:0] bits;
		bits = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			bits[b*8 +: 8] = {8{sel[b]}};
		end
		return bits;
	endfunction : lane_bits

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	gos_bus_state_e bus_state;
	gos_bus_state_e next_bus_state;
	logic next_ack;
	logic [31:0] next_dat;
	logic [63:0] mask;
	logic [63:0] next_mask;
	logic [63:0] event_set;
	logic [63:0] clear_pulse;
	logic [63:0] status_flags;
	logic take;
	logic take_write;
	gos_reg_sel_e take_sel;
	logic [31:0] write_bits;

	// ------------------------------------------------------------------
	// event collection
	// ------------------------------------------------------------------
	// place each event at its status position; reserved positions stay 0
	always_comb begin
		event_set = 64'h0000_0000_0000_0000;
		event_set[BIT_GP_COUNTER0 + 0] = gp_counter0_overflow_in;
		event_set[BIT_GP_COUNTER0 + 1] = gp_counter1_overflow_in;
		event_set[BIT_GP_COUNTER0 + 2] = gp_counter2_overflow_in;
		event_set[BIT_GP_COUNTER0 + 3] = gp_counter3_overflow_in;
		event_set[BIT_FIXED_COUNTER0 + 0] = fixed_counter0_overflow_in;
		event_set[BIT_FIXED_COUNTER0 + 1] = fixed_counter1_overflow_in;
		event_set[BIT_FIXED_COUNTER0 + 2] = fixed_counter2_overflow_in;
		event_set[BIT_TRACE_TABLE] = trace_table_interrupt_in;
		event_set[BIT_UNCORE] = uncore_overflow_in;
		event_set[BIT_DEBUG_STORE] = debug_store_save_overflow_in;
		event_set[BIT_CONDITION] = condition_changed_in;
	end

	// ------------------------------------------------------------------
	// bus request decode
	// ------------------------------------------------------------------
	// a request is taken once, in the idle state
	always_comb begin
		take = wb_cyc_in & wb_stb_in & (bus_state == GOS_BUS_IDLE);
		take_write = take & wb_we_in;
		take_sel = decode_word(wb_adr_in);
		write_bits = wb_dat_in & lane_bits(wb_sel_in);
	end

	// ------------------------------------------------------------------
	// clear register: write-one pulses, never stored
	// ------------------------------------------------------------------
	always_comb begin
		clear_pulse = 64'h0000_0000_0000_0000;
		if (take_write && take_sel == GOS_SEL_CLEAR_LO) begin
			clear_pulse[31:0] = write_bits;
		end
		if (take_write && take_sel == GOS_SEL_CLEAR_HI) begin
			clear_pulse[63:32] = write_bits;
		end
	end

	// status flags; only implemented positions can ever set
	gos_sticky_bank #(
		.WIDTH(64),
		.RESET_VALUE(STATUS_RESET)
	) u_status (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.set_in(event_set & IMPL_BITS),
		.clear_in(clear_pulse),
		.flags_out(status_flags)
	);

	// ------------------------------------------------------------------
	// interrupt mask register
	// ------------------------------------------------------------------
	always_comb begin
		next_mask = mask;
		if (take_write && take_sel == GOS_SEL_MASK_LO) begin
			next_mask[31:0] = (mask[31:0] & ~lane_bits(wb_sel_in)) | write_bits;
		end
		if (take_write && take_sel == GOS_SEL_MASK_HI) begin
			next_mask[63:32] = (mask[63:32] & ~lane_bits(wb_sel_in)) | write_bits;
		end
		next_mask = next_mask & IMPL_BITS;
	end

	// mask register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mask <= MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	// level interrupt from enabled flags
	gos_irq_gate #(
		.WIDTH(64)
	) u_irq (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.status_in(status_flags),
		.mask_in(mask),
		.irq_out(irq_out)
	);

	// ------------------------------------------------------------------
	// bus answer state machine
	// ------------------------------------------------------------------
	// ack one cycle after take, dropped in the following cycle
	always_comb begin
		next_bus_state = bus_state;
		next_ack = 1'b0;
		next_dat = wb_dat_out;
		unique case (bus_state)
			GOS_BUS_IDLE: begin
				if (take) begin
					next_bus_state = GOS_BUS_ACK;
					next_ack = 1'b1;
					next_dat = READ_ZERO;
					if (!wb_we_in) begin
						unique case (take_sel)
							GOS_SEL_STATUS_LO: next_dat = status_flags[31:0];
							GOS_SEL_STATUS_HI: next_dat = status_flags[63:32];
							GOS_SEL_MASK_LO: next_dat = mask[31:0];
							GOS_SEL_MASK_HI: next_dat = mask[63:32];
							default: next_dat = READ_ZERO; // clear words, unmapped
						endcase
					end
				end
			end
			GOS_BUS_ACK: begin
				next_bus_state = GOS_BUS_IDLE;
				next_dat = READ_ZERO;
			end
			default: begin
				next_bus_state = GOS_BUS_IDLE;
				next_dat = READ_ZERO;
			end
		endcase
	end

	// bus registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			bus_state <= GOS_BUS_IDLE;
			wb_ack_out <= 1'b0;
			wb_dat_out <= READ_ZERO;
		end else begin
			bus_state <= next_bus_state;
			wb_ack_out <= next_ack;
			wb_dat_out <= next_dat;
		end
	end

	// status mirror straight from the flag flops
	assign global_overflow_status_out = status_flags;

endmodule : gos_global_overflow_status_clear

/* File: gos_irq_gate.sv */
/*
 * gos_irq_gate: registered level interrupt from status flags and a mask.
 * Assumes status and mask are on the same clock; one cycle of latency.
 */
`timescale 1ns/1ps
module gos_irq_gate #(
	parameter int WIDTH = 64
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] status_in,
	input wire logic [WIDTH-1:0] mask_in,
	output logic irq_out
);

	logic next_irq;

	// high while any enabled flag stands
	always_comb begin
		next_irq = |(status_in & mask_in);
	end

	// interrupt register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= next_irq;
		end
	end

endmodule : gos_irq_gate

/* File: gos_pkg.sv */
/*
 * gos_pkg: constants for the global overflow status / clear register bank.
 * Assumes a 32-bit classic Wishbone register bus; 64-bit registers are split
 * into two aligned words, the low word at the register's byte address.
 */
package gos_pkg;

	// ------------------------------------------------------------------
	// register indices and byte addresses
	// ------------------------------------------------------------------
	localparam logic [9:0] REG_STATUS_IDX = 10'h38E;
	localparam logic [9:0] REG_CLEAR_IDX = 10'h390;
	localparam logic [9:0] REG_MASK_IDX = 10'h392;
	localparam logic [11:0] ADR_STATUS_LO = {REG_STATUS_IDX, 2'b00};
	localparam logic [11:0] ADR_STATUS_HI = {REG_STATUS_IDX + 10'h001, 2'b00};
	localparam logic [11:0] ADR_CLEAR_LO = {REG_CLEAR_IDX, 2'b00};
	localparam logic [11:0] ADR_CLEAR_HI = {REG_CLEAR_IDX + 10'h001, 2'b00};
	localparam logic [11:0] ADR_MASK_LO = {REG_MASK_IDX, 2'b00};
	localparam logic [11:0] ADR_MASK_HI = {REG_MASK_IDX + 10'h001, 2'b00};

	// ------------------------------------------------------------------
	// field positions of the status / clear / mask layout
	// ------------------------------------------------------------------
	localparam int BIT_GP_COUNTER0 = 0;
	localparam int GP_COUNTERS = 4;
	localparam int BIT_FIXED_COUNTER0 = 32;
	localparam int FIXED_COUNTERS = 3;
	localparam int BIT_TRACE_TABLE = 55;
	localparam int BIT_UNCORE = 61;
	localparam int BIT_DEBUG_STORE = 62;
	localparam int BIT_CONDITION = 63;
	localparam logic [63:0] IMPL_BITS = 64'hE080_0007_0000_000F;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [63:0] STATUS_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] MASK_RESET = 64'h0000_0000_0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		GOS_BUS_IDLE = 2'b00,
		GOS_BUS_ACK = 2'b01
	} gos_bus_state_e;

	typedef enum logic [2:0] {
		GOS_SEL_NONE = 3'b000,
		GOS_SEL_STATUS_LO = 3'b001,
		GOS_SEL_STATUS_HI = 3'b011,
		GOS_SEL_CLEAR_LO = 3'b010,
		GOS_SEL_CLEAR_HI = 3'b110,
		GOS_SEL_MASK_LO = 3'b111,
		GOS_SEL_MASK_HI = 3'b101
	} gos_reg_sel_e;

endpackage : gos_pkg

/* File: gos_properties.sv */
/*
 * gos_properties: port-level checks of the overflow status bank.
 * Assumes it is bound into the top module and shares its single clock.
 */
`timescale 1ns/1ps
module gos_properties
	import gos_pkg::*;
#(
	parameter int ADR_W = 12
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic gp_counter0_overflow_in,
	input wire logic gp_counter1_overflow_in,
	input wire logic gp_counter2_overflow_in,
	input wire logic gp_counter3_overflow_in,
	input wire logic fixed_counter0_overflow_in,
	input wire logic fixed_counter1_overflow_in,
	input wire logic fixed_counter2_overflow_in,
	input wire logic trace_table_interrupt_in,
	input wire logic uncore_overflow_in,
	input wire logic debug_store_save_overflow_in,
	input wire logic condition_changed_in,
	input wire logic [63:0] global_overflow_status_out,
	input wire logic irq_out
);
	logic [31:0] byte_mask;
	logic [63:0] ev;
	logic [63:0] clr;
	logic take;

	// ------------------------------------------------------------------
	// events and clears in the status layout
	// ------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			byte_mask[8*i+:8] = {8{wb_sel_in[i]}};
		end
		take = wb_cyc_in && wb_stb_in && !wb_ack_out;
		clr = 64'h0;
		if (take && wb_we_in && wb_adr_in == ADR_W'(ADR_CLEAR_LO)) begin
			clr[31:0] = wb_dat_in & byte_mask;
		end
		if (take && wb_we_in && wb_adr_in == ADR_W'(ADR_CLEAR_HI)) begin
			clr[63:32] = wb_dat_in & byte_mask;
		end
		ev = {condition_changed_in, debug_store_save_overflow_in, uncore_overflow_in, 5'h00,
			trace_table_interrupt_in, 20'h00000, fixed_counter2_overflow_in,
			fixed_counter1_overflow_in, fixed_counter0_overflow_in, 28'h0000000,
			gp_counter3_overflow_in, gp_counter2_overflow_in, gp_counter1_overflow_in,
			gp_counter0_overflow_in};
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_answer;
		s_take ##1 wb_ack_out;
	endsequence
	// next flags: old flags less ones written, plus new events (set wins)
	property p_flags(logic [63:0] m);
		1'b1 |=> (global_overflow_status_out & m) ==
			((($past(global_overflow_status_out) & ~$past(clr)) | $past(ev)) & m);
	endproperty

	a_gp_flags: assert property (p_flags(64'h0000_0000_0000_000F))
		else $error("general counter flags wrong");
	a_fixed_flags: assert property (p_flags(64'h0000_0007_0000_0000))
		else $error("fixed counter flags wrong");
	a_trace_flag: assert property (p_flags(64'h0080_0000_0000_0000))
		else $error("trace table flag wrong");
	a_uncore_flag: assert property (p_flags(64'h2000_0000_0000_0000))
		else $error("uncore flag wrong");
	a_store_flag: assert property (p_flags(64'h4000_0000_0000_0000))
		else $error("debug store flag wrong");
	a_cond_flag: assert property (p_flags(64'h8000_0000_0000_0000))
		else $error("condition flag wrong");
	a_reserved_zero: assert property ((global_overflow_status_out & ~IMPL_BITS) == 64'h0)
		else $error("reserved status bit set");
	a_sticky_hold: assert property (clr == 64'h0 |=>
		($past(global_overflow_status_out) & ~global_overflow_status_out) == 64'h0)
		else $error("flag lost without clear");
	a_ack_follows: assert property (s_take |=> wb_ack_out)
		else $error("no ack one cycle after request");
	a_ack_single: assert property (s_answer |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	a_idle_data: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
		else $error("read data outside ack");
endmodule : gos_properties

bind gos_global_overflow_status_clear gos_properties #(.ADR_W(ADR_W)) i_gos_properties (.*);

/* File: gos_sticky_bank.sv */
/*
 * gos_sticky_bank: a row of sticky flags, set by hardware pulses, cleared by
 * per-bit clear pulses. Assumes set and clear come from the same clock.
 */
`timescale 1ns/1ps
module gos_sticky_bank #(
	parameter int WIDTH = 64,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clear_in,
	output logic [WIDTH-1:0] flags_out
);

	logic [WIDTH-1:0] next_flags;

	// ------------------------------------------------------------------
	// next flag values
	// ------------------------------------------------------------------
	// per bit: a set in the clear cycle wins, zero in clear keeps the flag
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_flags[i] = set_in[i] | (flags_out[i] & ~clear_in[i]);
		end
	end

	// flag register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flags_out <= RESET_VALUE;
		end else begin
			flags_out <= next_flags;
		end
	end

endmodule : gos_sticky_bank

/* File: tb_top.sv */
/*
 * tb_top: self-checking bench of the overflow status bank over Wishbone.
 * Assumes the bank's package and the bound checker are compiled first.
 */
`timescale 1ns/1ps
module tb_top
	import gos_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, irq_out, ev_on, ev_all, took;
	logic [11:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in, wb_dat_out;
	logic [63:0] global_overflow_status_out, exp_st, exp_msk;
	logic [10:0] evs = 11'h000;
	logic [11:0] adr_tab [6] = '{ADR_CLEAR_LO, ADR_CLEAR_HI, ADR_MASK_LO, ADR_MASK_HI,
		ADR_STATUS_LO, 12'h000};
	int seed = 32'h7ef920d7;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;

	gos_global_overflow_status_clear i_gos_global_overflow_status_clear (.*,
		.gp_counter0_overflow_in(evs[0]), .gp_counter1_overflow_in(evs[1]),
		.gp_counter2_overflow_in(evs[2]), .gp_counter3_overflow_in(evs[3]),
		.fixed_counter0_overflow_in(evs[4]), .fixed_counter1_overflow_in(evs[5]),
		.fixed_counter2_overflow_in(evs[6]), .trace_table_interrupt_in(evs[7]),
		.uncore_overflow_in(evs[8]), .debug_store_save_overflow_in(evs[9]),
		.condition_changed_in(evs[10]));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [63:0] place(input logic [31:0] v, input logic sel, input logic hi);
		logic [31:0] m;
		for (int i = 0; i < 4; i++) m[8*i+:8] = {8{wb_sel_in[i] | sel}};
		return hi ? {v & m, 32'h0} : {32'h0, v & m};
	endfunction : place

	task automatic complete_run();
		if (error_cnt == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	// one classic Wishbone cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		wb_sel_in <= s;
		// only the bench timeout ends a wait that never sees ack
		do begin
			@(posedge clk_in);
			n++;
		end while (wb_ack_out !== 1'b1);
		q = wb_dat_out;
		chk({63'h0, n == 2}, 64'h1, "ack latency");
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
		@(posedge clk_in);
	endtask : wb

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, 4'hF, q);
		chk({32'h0, q}, {32'h0, e}, "read data");
	endtask : rd_chk

	// clock, timeout and random events
	initial forever #10 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		evs <= ev_all ? 11'h7FF : ev_on ? 11'($random(seed) & $random(seed)) : 11'h000;
		if (cycles == 20000) begin
			chk(64'h0, 64'h1, "timeout");
			complete_run();
		end
	end

	// reference flags and mask from the bus traffic
	always @(posedge clk_in) begin
		logic tk;
		logic [63:0] v;
		logic [63:0] m;
		tk = wb_cyc_in && wb_stb_in && wb_we_in && !took;
		v = place(wb_dat_in, 1'b0, wb_adr_in[2]);
		m = place(32'hFFFF_FFFF, 1'b0, wb_adr_in[2]);
		took <= rst_in ? 1'b0 : wb_cyc_in && wb_stb_in && !took;
		if (rst_in) begin
			exp_st <= STATUS_RESET;
			exp_msk <= MASK_RESET;
		end else begin
			exp_st <= (exp_st & ~((tk && wb_adr_in[11:3] == ADR_CLEAR_LO[11:3]) ? v : 64'h0)) |
				{evs[10:8], 5'h00, evs[7], 20'h00000, evs[6:4], 28'h0000000, evs[3:0]};
			if (tk && wb_adr_in[11:3] == ADR_MASK_LO[11:3]) exp_msk <= ((exp_msk & ~m) | v) & IMPL_BITS;
		end
	end

	// flags compared every cycle where settled
	always @(negedge clk_in) begin
		if (!rst_in) chk(global_overflow_status_out, exp_st, "status flags");
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [31:0] q;
		{rst_in, wb_cyc_in, wb_stb_in, wb_we_in, ev_on, ev_all} = 6'b100000;
		{wb_adr_in, wb_sel_in, wb_dat_in} = 48'h0;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		rd_chk(ADR_STATUS_LO, 32'h0);
		rd_chk(ADR_MASK_HI, 32'h0);
		// every event at once, zero clears keep them, ones clear them
		ev_all <= 1'b1;
		@(posedge clk_in);
		ev_all <= 1'b0;
		wb(1'b1, ADR_CLEAR_LO, 32'h0, 4'hF, q);
		wb(1'b1, ADR_CLEAR_HI, 32'h0, 4'hF, q);
		rd_chk(ADR_STATUS_HI, 32'hE080_0007);
		rd_chk(ADR_STATUS_LO, 32'h0000_000F);
		wb(1'b1, ADR_CLEAR_HI, 32'hFFFF_FFFF, 4'hF, q);
		wb(1'b1, ADR_CLEAR_LO, 32'hFFFF_FFFF, 4'hF, q);
		// corner: events and a clear of ones at the same edge, the set wins
		ev_all <= 1'b1;
		@(posedge clk_in);
		ev_all <= 1'b0;
		wb(1'b1, ADR_CLEAR_HI, 32'hFFFF_FFFF, 4'hF, q);
		rd_chk(ADR_STATUS_HI, 32'hE080_0007);
		// random writes under random events, then quiet reads
		for (int i = 0; i < 40; i++) begin
			ev_on <= 1'b1;
			wb(1'b1, adr_tab[($random(seed) & 32'h7FFF_FFFF) % 6], $random(seed),
				4'($random(seed)), q);
			ev_on <= 1'b0;
			repeat (3) @(posedge clk_in);
			chk({63'h0, irq_out}, {63'h0, |(exp_st & exp_msk)}, "interrupt level");
			rd_chk(ADR_STATUS_LO, exp_st[31:0]);
			rd_chk(ADR_STATUS_HI, exp_st[63:32]);
			rd_chk(ADR_MASK_LO, exp_msk[31:0]);
			rd_chk(ADR_MASK_HI, exp_msk[63:32]);
		end
		rd_chk(ADR_CLEAR_LO, 32'h0);
		rd_chk(12'h000, 32'h0);
		complete_run();
	end
endmodule : tb_top
